// ### rtl/app_post_path.sv
// Post-conversion digital path: bypass pipe, gain stage, DC offset trim, output FIFO.
// Assumes raw samples and control bits come from logic on core_clk (no synchronisers).
//
// How it works
// - Fast path: raw sample reaches out_data eleven clocks after it is captured, no processing.
// - Processed path adds extra pipeline clocks beyond the bypass latency.
// - Reset gives fast path; disable_fast_path must be 1 before functions act.
// - Gain programmable 0 to 6 dB in 0.5 dB steps.
// - Each gain scales full scale: 2 Vpp at 0 dB down to 1 Vpp at 6 dB.
// - Leaving fast path enables gain stage at the gain_code setting already held in gain_q.
// - After reset gain is off while fast path is active.
// - Offset loop cancels DC offset of at most ten millivolts either way.
// - With dc_trim_enable set outside fast path, offset is estimated and corrected on every valid sample.
// - Four-bit tau select: 1M clocks at 0000, doubling, 2G at 1011, rest reserved.
// - dc_trim_hold freezes estimate; last value corrects every later sample.
// - Offset correction is off after reset.
// - Time constant counted in sampling clocks, so seconds scale with clock rate.
// - Each sample advances one pipeline stage per rising clock edge while the FIFO has room.
`timescale 1ns/1ps
module app_post_path #(
	parameter int W = app_pkg::SAMPLE_W,
	parameter int LAT = app_pkg::BYPASS_LAT,
	parameter int EXTRA = app_pkg::PROC_EXTRA,
	parameter int DEPTH = app_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Raw converter samples, twos complement
	input wire logic raw_valid,
	input wire logic [W-1:0] raw_data,
	// Control bits
	input wire logic disable_fast_path,
	input wire logic [3:0] gain_code,
	input wire logic dc_trim_enable,
	input wire logic [3:0] dc_trim_tau_select,
	input wire logic dc_trim_hold,
	// Output samples toward the receiver
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	// Status
	output logic raw_ready,
	output logic fast_path_q,
	output logic [W-1:0] offset_est_q
);
	localparam int TOT = LAT + EXTRA;
	localparam int AF = app_pkg::ACC_FRAC;
	localparam int AW = W + AF;
	localparam int GF = app_pkg::GAIN_FRAC;

	// ------------------------------------------------------------
	// Gain lookup: 2^14 * 10^(dB/20), codes are dB times two
	// ------------------------------------------------------------
	// Entries are rounded to the nearest step of 2^-14
	function automatic logic [15:0] gain_mult(input logic [3:0] code);
		logic [15:0] m;
		m = 16'h4000;
		unique case (code)
			4'h0: m = 16'h4000;
			4'h1: m = 16'h43cb;
			4'h2: m = 16'h47cf;
			4'h3: m = 16'h4c10;
			4'h4: m = 16'h5092;
			4'h5: m = 16'h5558;
			4'h6: m = 16'h5a67;
			4'h7: m = 16'h5fc2;
			4'h8: m = 16'h656f;
			4'h9: m = 16'h6b72;
			4'ha: m = 16'h71cf;
			4'hb: m = 16'h788e;
			4'hc: m = 16'h7fb2;
			default: m = 16'h4000;
		endcase
		return m;
	endfunction : gain_mult

	// Saturate a wide signed value into W bits
	function automatic logic [W-1:0] sat(input logic signed [W+17:0] v);
		logic signed [W+17:0] hi;
		logic signed [W+17:0] lo;
		hi = (W+18)'(signed'((2 ** (W-1)) - 1));
		lo = -(W+18)'(signed'(2 ** (W-1)));
		if (v > hi)
			return hi[W-1:0];
		else if (v < lo)
			return lo[W-1:0];
		else
			return v[W-1:0];
	endfunction : sat

	// ------------------------------------------------------------
	// Mode control
	// ------------------------------------------------------------
	logic fast_q;
	wire fifo_ready;
	wire adv;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			fast_q <= ~app_pkg::FAST_PATH_RESET;
		else
			fast_q <= ~disable_fast_path;
	end

	// Back-pressure from the FIFO stalls the whole pipe
	assign adv = fifo_ready;

	// ------------------------------------------------------------
	// Raw pipe: one stage per edge while the FIFO has room, shared by both paths
	// ------------------------------------------------------------
	logic [W-1:0] pipe_q [TOT];
	logic [TOT-1:0] pv_q;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			pv_q <= '0;
		else if (adv)
			pv_q <= {pv_q[TOT-2:0], raw_valid};
	end

	always_ff @(posedge core_clk)
	begin
		if (adv)
		begin
			pipe_q[0] <= raw_data;
			for (int i = 1; i < TOT; i++)
				pipe_q[i] <= pipe_q[i-1];
		end
	end

	// ------------------------------------------------------------
	// Processing stages tapped from the pipe at stage LAT-1
	// ------------------------------------------------------------
	logic [3:0] gain_q;
	logic [15:0] mult_q;
	logic signed [W+17:0] prod_q;
	logic [W-1:0] scaled_q;
	logic [W-1:0] corr_q;
	logic trim_on_q;
	logic signed [AW-1:0] acc_q;
	logic [3:0] tau_q;
	wire [W-1:0] tap;
	wire signed [W+17:0] prod_d;
	wire signed [W+17:0] corr_d;
	wire signed [AW-1:0] err;
	wire signed [AW-1:0] acc_d;
	wire signed [AW-1:0] acc_lim;
	wire [5:0] shift;

	// Three register stages follow the tap, so the corrected word
	// lines up with the valid bit at stage TOT-1
	assign tap = pipe_q[LAT-1];

	// Gain code filter, unused codes become 0 dB
	// Gain register follows gain_code every clock, in fast path or not
	always_ff @(posedge core_clk)
	begin
		if (rst)
			gain_q <= app_pkg::GAIN_RESET;
		else
			gain_q <= (gain_code > app_pkg::GAIN_MAX_CODE) ? app_pkg::GAIN_RESET : gain_code;
	end

	assign prod_d = (W+18)'(signed'(tap) * signed'({1'b0, mult_q}));
	assign corr_d = (W+18)'(signed'(scaled_q)) - (W+18)'(signed'(offset_est_q));

	// Tau code to shift, reserved codes clamp to the longest
	assign shift = 6'(app_pkg::TAU_BASE_SHIFT)
		+ ((tau_q > app_pkg::TAU_MAX_CODE) ? 6'(app_pkg::TAU_MAX_CODE) : 6'(tau_q));

	// Leak per sample: count of clocks, not seconds
	assign err = AW'(signed'(scaled_q)) <<< AF;
	assign acc_d = acc_q + ((err - acc_q) >>> shift);

	// Estimate limited to about 10 mV
	assign acc_lim = (acc_d > (AW'(app_pkg::OFFS_LIMIT) <<< AF)) ? (AW'(app_pkg::OFFS_LIMIT) <<< AF)
		: (acc_d < -(AW'(app_pkg::OFFS_LIMIT) <<< AF)) ? -(AW'(app_pkg::OFFS_LIMIT) <<< AF) : acc_d;

	// Gain stage registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			mult_q <= 16'h4000;
			prod_q <= '0;
			scaled_q <= '0;
		end
		else if (adv)
		begin
			mult_q <= gain_mult(gain_q);
			prod_q <= prod_d;
			scaled_q <= sat(prod_q >>> GF);
		end
	end

	// Trim only acts once fast path is left
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			trim_on_q <= app_pkg::TRIM_EN_RESET;
			tau_q <= app_pkg::TAU_RESET;
		end
		else
		begin
			trim_on_q <= dc_trim_enable && !fast_q;
			tau_q <= dc_trim_tau_select;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || !trim_on_q)
			acc_q <= '0;
		// Valid bit at LAT+1 travels with the word in scaled_q
		else if (adv && pv_q[LAT+1] && !dc_trim_hold)
			acc_q <= acc_lim;
	end

	// Correction applied to every sample while on
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			offset_est_q <= '0;
			corr_q <= '0;
		end
		else
		begin
			offset_est_q <= trim_on_q ? acc_q[AW-1:AF] : '0;
			if (adv)
				corr_q <= sat(corr_d);
		end
	end

	// ------------------------------------------------------------
	// Output selection into the FIFO
	// ------------------------------------------------------------
	wire [W-1:0] sel_data;
	wire sel_valid;
	// FIFO drain side, feeds the output register
	wire fifo_out_valid;
	wire fifo_take;
	wire [W-1:0] fifo_out_data;

	// Bypass tap: ten stages, counting the FIFO as none
	// Gain unused while fast path is active
	assign sel_data = fast_q ? pipe_q[LAT-1] : corr_q;
	assign sel_valid = adv && (fast_q ? pv_q[LAT-1] : pv_q[TOT-1]);

	app_fifo #(
		.WIDTH(W),
		.DEPTH(DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(sel_valid),
		.in_ready(fifo_ready),
		.in_data(sel_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_take),
		.out_data(fifo_out_data)
	);

	// Output register stage, straight from flops
	assign fifo_take = fifo_out_valid && (!out_valid || out_ready);

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			out_valid <= 1'b0;
			out_data <= '0;
			raw_ready <= 1'b0;
			fast_path_q <= 1'b1;
		end
		else
		begin
			if (fifo_take)
			begin
				out_valid <= 1'b1;
				out_data <= fifo_out_data;
			end
			else if (out_ready)
				out_valid <= 1'b0;
			raw_ready <= fifo_ready;
			fast_path_q <= fast_q;
		end
	end
endmodule : app_post_path

// ### common/app_pkg.sv
// Package for the ADC post-processing path: widths, latencies, field codes.
// Assumes one sampling clock drives every flip-flop of the path.
package app_pkg;

	// ------------------------------------------------------------
	// Sample and pipeline figures
	// ------------------------------------------------------------
	localparam int SAMPLE_W = 14;
	localparam int BYPASS_LAT = 10;
	localparam int PROC_EXTRA = 3;
	localparam int FIFO_DEPTH = 16;

	// ------------------------------------------------------------
	// Gain field: code is dB times two
	// ------------------------------------------------------------
	localparam int GAIN_W = 4;
	localparam logic [3:0] GAIN_RESET = 4'h0;
	localparam logic [3:0] GAIN_MAX_CODE = 4'hc;
	localparam int GAIN_FRAC = 14;

	// ------------------------------------------------------------
	// Offset loop
	// ------------------------------------------------------------
	localparam logic [3:0] TAU_RESET = 4'h0;
	localparam logic [3:0] TAU_MAX_CODE = 4'hb;
	localparam int TAU_BASE_SHIFT = 20;
	localparam int ACC_FRAC = 32;
	// Largest correction in codes; 10 mV of a 2 Vpp, 14-bit range is about 82
	localparam int OFFS_LIMIT = 82;

	// Reset values of control bits
	localparam logic FAST_PATH_RESET = 1'b0;
	localparam logic TRIM_EN_RESET = 1'b0;
	localparam logic TRIM_HOLD_RESET = 1'b0;

endpackage : app_pkg

// ### rtl/app_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes write and read share one clock; width and depth are parameters.
`timescale 1ns/1ps
module app_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	wire do_wr;
	wire do_rd;

	// Handshake decode
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;
	assign out_data = mem[rd_q];

	// Storage write
	always_ff @(posedge core_clk)
	begin
		if (do_wr)
			mem[wr_q] <= in_data;
	end

	// Pointers and fill count
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (do_wr)
				wr_q <= AW'(wr_q + 1'b1);
			if (do_rd)
				rd_q <= AW'(rd_q + 1'b1);
			cnt_q <= (AW+1)'(cnt_q + do_wr - do_rd);
		end
	end
endmodule : app_fifo

// ### sim/app_post_path_props.sv
// Checker for the post-path top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module app_post_path_props (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Controls
	input wire logic disable_fast_path,
	input wire logic dc_trim_enable,
	input wire logic dc_trim_hold,
	// Outputs
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [13:0] out_data,
	input wire logic raw_ready,
	input wire logic fast_path_q,
	input wire logic [13:0] offset_est_q
);
	// ------------------------------------------------
	// Port relations
	// ------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Nothing can leave the pipe this early
	sequence quiet_s;
		(!out_valid)[*8];
	endsequence
	reset_state_a: assert property ($fell(rst) |-> fast_path_q && !raw_ready && offset_est_q == 14'h0)
		else $error("state after reset wrong");
	fast_mode_a: assert property (!$past(rst) && !$past(rst, 2)
		|-> fast_path_q != $past(disable_fast_path, 2))
		else $error("fast path flag does not follow control");
	trim_off_a: assert property ((!dc_trim_enable)[*3] |-> offset_est_q == 14'h0)
		else $error("estimate nonzero with trim off");
	fast_no_trim_a: assert property (fast_path_q[*2] |-> offset_est_q == 14'h0)
		else $error("estimate nonzero in fast path");
	hold_freeze_a: assert property ((dc_trim_hold && dc_trim_enable && !fast_path_q)[*2] |=> $stable(offset_est_q))
		else $error("estimate moved while held");
	est_limit_a: assert property ($signed(offset_est_q) <= 82 && $signed(offset_est_q) >= -82)
		else $error("estimate beyond limit");
	out_stands_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("output word dropped before taken");
	quiet_start_a: assert property ($fell(rst) |-> quiet_s)
		else $error("output too soon after reset");
endmodule : app_post_path_props

// ### sim/app_rx_model.sv
// Receiver model: takes output words, stalls on command.
// Assumes valid/ready handshake on core_clk.
`timescale 1ns/1ps
module app_rx_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Bench control
	input wire logic stall,
	// Sample port
	input wire logic out_valid,
	output logic out_ready,
	input wire logic [13:0] out_data,
	// Observed words
	output logic [13:0] last_q,
	output int count_q,
	output logic order_err_q
);
	// Ready drops while stalled
	assign out_ready = !stall;
	// Take a word when valid meets ready; flag a non-rising word
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			count_q <= 0;
			last_q <= 14'h0;
			order_err_q <= 1'b0;
		end
		else if (out_valid && out_ready)
		begin
			count_q <= count_q + 1;
			last_q <= out_data;
			order_err_q <= order_err_q || (count_q > 0 && out_data <= last_q);
		end
	end
endmodule : app_rx_model

// ### sim/tb.sv
// Testbench for the post-conversion path.
// Assumes a 50 MHz core_clk and the receiver model.
`timescale 1ns/1ps
module tb;
	logic core_clk, rst, raw_valid, disable_fast_path, dc_trim_enable, dc_trim_hold;
	logic out_valid, out_ready, raw_ready, fast_path_q, stall, order_err_q;
	logic [13:0] raw_data, out_data, offset_est_q, last_q;
	logic [3:0] gain_code, dc_trim_tau_select;
	int count_q, fail_count, n_tests;
	// Design and far side
	app_post_path dut (.core_clk, .rst, .raw_valid, .raw_data, .disable_fast_path, .gain_code,
		.dc_trim_enable, .dc_trim_tau_select, .dc_trim_hold, .out_valid, .out_ready, .out_data,
		.raw_ready, .fast_path_q, .offset_est_q);
	app_rx_model rx (.core_clk, .rst, .stall, .out_valid, .out_ready, .out_data, .last_q, .count_q, .order_err_q);
	// Clock
	always #10 core_clk = ~core_clk;
	// ------------------------------------------------
	// Shared tasks
	// ------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic do_reset();
		rst <= 1'b1;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : do_reset
	// One marked sample; edges until it shows at the port
	task automatic mark(input logic [13:0] v, output int lat);
		lat = 0;
		raw_data <= v;
		@(posedge core_clk);
		raw_data <= 14'h0;
		while (!(out_valid === 1'b1 && out_data === v) && lat < 40)
		begin
			@(posedge core_clk);
			lat++;
		end
		chk({13'h0, lat < 40}, 14'h1);
		if (lat >= 40)
			close_out();
	endtask : mark
	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task automatic t_latency();
		int lb, lp;
		dc_trim_enable <= 1'b1;
		gain_code <= 4'hc;
		do_reset();
		repeat (20) @(posedge core_clk);
		chk({13'h0, fast_path_q}, 14'h1);
		chk(offset_est_q, 14'h0);
		dc_trim_enable <= 1'b0;
		mark(14'h1f4, lb);
		chk({13'h0, lb >= app_pkg::BYPASS_LAT && lb <= app_pkg::BYPASS_LAT + 3}, 14'h1);
		disable_fast_path <= 1'b1;
		gain_code <= 4'h0;
		repeat (30) @(posedge core_clk);
		mark(14'h1f4, lp);
		chk(14'(lp - lb), 14'(app_pkg::PROC_EXTRA));
		$display("latency test done");
	endtask : t_latency
	task automatic t_gain();
		logic [13:0] e;
		logic [13:0] exp_t [13] = '{14'h3e8, 14'h423, 14'h462, 14'h4a5, 14'h4eb, 14'h536, 14'h585,
			14'h5d8, 14'h631, 14'h68f, 14'h6f2, 14'h75c, 14'h7cb};
		for (int g = 0; g < 16; g++)
		begin
			gain_code <= 4'(g);
			raw_data <= 14'h3e8;
			repeat (30) @(posedge core_clk);
			e = (g < 13) ? exp_t[g] : 14'h3e8;
			chk({13'h0, last_q + 14'h2 >= e && last_q <= e + 14'h2}, 14'h1);
		end
		gain_code <= 4'h0;
		$display("gain test done");
	endtask : t_gain
	task automatic t_trim();
		logic [13:0] est, prev;
		prev = 14'h0;
		for (int c = 0; c < 16; c++)
		begin
			dc_trim_enable <= 1'b0;
			dc_trim_hold <= 1'b0;
			dc_trim_tau_select <= 4'(c);
			do_reset();
			raw_data <= 14'h1f40;
			dc_trim_enable <= 1'b1;
			repeat (c == 0 ? 15000 : 3000) @(posedge core_clk);
			est = offset_est_q;
			if (c == 0)
			begin
				chk(est, 14'(app_pkg::OFFS_LIMIT));
				chk({13'h0, last_q + est >= 14'h1f3f && last_q + est <= 14'h1f41}, 14'h1);
				dc_trim_hold <= 1'b1;
				repeat (3) @(posedge core_clk);
				est = offset_est_q;
				raw_data <= 14'h2000;
				repeat (2000) @(posedge core_clk);
				chk(offset_est_q, est);
			end
			else if (c > 11)
				chk(est, prev);
			else
				chk({13'h0, est < prev || prev == 14'h0}, 14'h1);
			if (c <= 11)
				prev = est;
		end
		$display("trim test done");
	endtask : t_trim
	task automatic t_fifo();
		logic [13:0] v;
		logic low;
		dc_trim_enable <= 1'b0;
		dc_trim_hold <= 1'b0;
		disable_fast_path <= 1'b0;
		raw_valid <= 1'b0;
		stall <= 1'b1;
		do_reset();
		v = 14'h1;
		low = 1'b0;
		for (int i = 0; i < 60; i++)
		begin
			raw_valid <= 1'b1;
			raw_data <= v;
			v = v + 14'h1;
			@(posedge core_clk);
			low = low | (raw_ready === 1'b0);
		end
		chk({13'h0, low}, 14'h1);
		chk(14'(count_q), 14'h0);
		raw_valid <= 1'b0;
		stall <= 1'b0;
		repeat (80) @(posedge core_clk);
		chk({13'h0, count_q >= app_pkg::FIFO_DEPTH}, 14'h1);
		chk({12'h0, order_err_q, out_valid}, 14'h0);
		$display("fifo test done");
	endtask : t_fifo
	// Main sequence
	initial
	begin
		core_clk = 1'b0;
		rst = 1'b1;
		raw_valid = 1'b1;
		raw_data = 14'h0;
		disable_fast_path = 1'b0;
		gain_code = 4'h0;
		dc_trim_enable = 1'b0;
		dc_trim_tau_select = 4'h0;
		dc_trim_hold = 1'b0;
		stall = 1'b0;
		fail_count = 0;
		n_tests = 0;
		t_latency();
		t_gain();
		t_trim();
		t_fifo();
		close_out();
	end
endmodule : tb
bind app_post_path app_post_path_props u_props (.core_clk, .rst, .disable_fast_path, .dc_trim_enable,
	.dc_trim_hold, .out_valid, .out_ready, .out_data, .raw_ready, .fast_path_q, .offset_est_q);
